// file: core/pmx_params.svh
`ifndef PMX_PARAMS_SVH
`define PMX_PARAMS_SVH

// ==========================================================
// Pin set
`define PMX_NPIN 13
`define PMX_NSYNC 15
`define PMX_P_TDI 0
`define PMX_P_TDO 1
`define PMX_P_TCK 2
`define PMX_P_TMS 3
`define PMX_P_VBAT 4
`define PMX_P_IRQW 5
`define PMX_P_PS2A_CLK 6
`define PMX_P_PS2A_DAT 7
`define PMX_P_PS2B_CLK 8
`define PMX_P_PS2B_DAT 9
`define PMX_P_UART 10
`define PMX_P_STRAP 11
`define PMX_P_PECI 12
`define PMX_S_TPRST 13
`define PMX_S_VCCOK 14

// ==========================================================
// Register offsets
`define PMX_OFS_CTRL0 8'h00
`define PMX_OFS_CTRL_LAST 8'h30
`define PMX_OFS_INT_STS 8'h80
`define PMX_OFS_INT_MASK 8'h84
`define PMX_OFS_PIN_IN 8'h88
`define PMX_OFS_HOST_CFG 8'h8c
`define PMX_OFS_STATUS 8'h90

// ==========================================================
// Pin control fields
`define PMX_PU_BIT 0
`define PMX_OD_BIT 1
`define PMX_DIR_BIT 2
`define PMX_OUT_BIT 3
`define PMX_ID_LSB 4
`define PMX_ID_MSB 7
`define PMX_MUX_LSB 12
`define PMX_MUX_MSB 13
`define PMX_CTRL_WMASK 32'h0000_30ff

// ==========================================================
// Host configuration fields
`define PMX_HC_PWR_BIT 0
`define PMX_HC_OWN_BIT 1
`define PMX_HC_WMASK 32'h0000_0003

// ==========================================================
// Reset values
`define PMX_CTRL_RST 32'h0000_0000
`define PMX_CTRL_STRAP_RST 32'h0000_0001
`define PMX_CTRL_IRQW_RST 32'h0000_1000
`define PMX_PU_RST 13'h0800
`define PMX_WAKE_PINS 13'h0030

`endif

// file: core/pmx_pkg.sv
`include "pmx_params.svh"
`default_nettype none

package pmx_pkg;

  typedef enum logic [1:0] {
    PMX_MUX_GPIO = 2'b00,
    PMX_MUX_ALT1 = 2'b01,
    PMX_MUX_ALT2 = 2'b10,
    PMX_MUX_ALT3 = 2'b11
  } pmx_mux_t;

  typedef enum logic [3:0] {
    PMX_ID_OFF = 4'h0,
    PMX_ID_LOW = 4'h1,
    PMX_ID_HIGH = 4'h2,
    PMX_ID_RISE = 4'h3,
    PMX_ID_FALL = 4'h4,
    PMX_ID_BOTH = 4'h5
  } pmx_intdet_t;

  typedef logic [`PMX_NPIN-1:0] pmx_pins_t;

  function automatic pmx_mux_t pmx_f_mux(input logic [31:0] c);
    return pmx_mux_t'(c[`PMX_MUX_MSB:`PMX_MUX_LSB]);
  endfunction : pmx_f_mux

  function automatic pmx_intdet_t pmx_f_idet(input logic [31:0] c);
    return pmx_intdet_t'(c[`PMX_ID_MSB:`PMX_ID_LSB]);
  endfunction : pmx_f_idet

endpackage : pmx_pkg

`default_nettype wire

// file: core/pmx_evt_if.sv
`include "pmx_params.svh"
`default_nettype none

interface pmx_evt_if;
  import pmx_pkg::*;
  logic [`PMX_NSYNC-1:0] lvl;
  pmx_intdet_t idet [`PMX_NPIN];
  pmx_pins_t evt;
  modport sync (output lvl);
  modport det (input lvl, input idet, output evt);
  modport top (input lvl, input evt, output idet);
endinterface : pmx_evt_if

`default_nettype wire

// file: core/pmx_sync.sv
`include "pmx_params.svh"
`default_nettype none

module pmx_sync (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [`PMX_NSYNC-1:0] raw,
  pmx_evt_if.sync bus
);
  import pmx_pkg::*;

  logic [`PMX_NSYNC-1:0] s1_q;
  logic [`PMX_NSYNC-1:0] s2_q;
  logic [`PMX_NSYNC-1:0] s3_q;
  logic [`PMX_NSYNC-1:0] lvl_q;

  // ==========================================================
  // Three stages, level moves once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lvl_q <= '0;
    end else begin
      for (int i = 0; i < `PMX_NSYNC; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          lvl_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign bus.lvl = lvl_q;

endmodule : pmx_sync

`default_nettype wire

// file: core/pmx_intdet.sv
`include "pmx_params.svh"
`default_nettype none

module pmx_intdet (
  input wire logic clk_sys,
  input wire logic sys_rst,
  pmx_evt_if.det bus
);
  import pmx_pkg::*;

  pmx_pins_t prv_q;
  pmx_pins_t evt_d;
  pmx_pins_t off_vec;
  pmx_pins_t cur;

  assign cur = bus.lvl[`PMX_NPIN-1:0];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prv_q <= '0;
    end else begin
      prv_q <= cur;
    end
  end

  // ==========================================================
  // Event decode per pin
  always_comb begin
    evt_d = '0;
    off_vec = '0;
    for (int i = 0; i < `PMX_NPIN; i++) begin
      off_vec[i] = (bus.idet[i] == PMX_ID_OFF);
      case (bus.idet[i])
        PMX_ID_LOW: evt_d[i] = ~cur[i];
        PMX_ID_HIGH: evt_d[i] = cur[i];
        PMX_ID_RISE: evt_d[i] = cur[i] & ~prv_q[i];
        PMX_ID_FALL: evt_d[i] = ~cur[i] & prv_q[i];
        PMX_ID_BOTH: evt_d[i] = cur[i] ^ prv_q[i];
        default: evt_d[i] = 1'b0;
      endcase
    end
  end

  assign bus.evt = evt_d;

  property p_evt_needs_detect;
    @(posedge clk_sys) disable iff (sys_rst)
    (bus.evt & off_vec) == '0;
  endproperty
  a_evt_needs_detect: assert property (p_evt_needs_detect) // R05
    else $error("event raised on pin with detection off");

endmodule : pmx_intdet

`default_nettype wire

// file: core/pmx_top.sv
// How it works
// (R01) Test reset high: test port owns pins
// (R02) Test reset low: control registers pick function
// (R03) No register setting routes test port
// (R04) Battery pin: fixed direction, data bits disconnected
// (R05) Battery pin: only detection field acts
// (R06) PS/2 A and B share one controller
// (R07) Firmware uses one PS/2 segment only
// (R08) Wake-only pin: events from detection field only
// (R09) Firmware never sets wake-only pin to GPIO
// (R10) Wake pins give wake and interrupt detection
// (R11) Debug UART: host or EC, power protect
// (R12) Strap pin leaves reset with pull-up on
// (R13) Firmware sets PECI request pin open-drain
// (R14) One control register per pin selects function
`include "pmx_params.svh"
`default_nettype none

module pmx_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire pmx_pkg::pmx_pins_t pin_i,
  output pmx_pkg::pmx_pins_t pin_o,
  output pmx_pkg::pmx_pins_t pin_oe,
  output pmx_pkg::pmx_pins_t pin_pu,
  input wire logic tp_rst_n,
  input wire logic vcc_pwrgd,
  input wire logic tp_tdo,
  output logic tp_tdi,
  output logic tp_tck,
  output logic tp_tms,
  output logic tp_owned,
  input wire logic ps2_clk_low,
  input wire logic ps2_dat_low,
  output logic ps2_clk_in,
  output logic ps2_dat_in,
  input wire logic uart_tx_host,
  input wire logic uart_tx_ec,
  input wire logic peci_req_low,
  output logic irq,
  output logic wake
);
  import pmx_pkg::*;

  pmx_evt_if bus ();

  logic [31:0] ctrl_q [`PMX_NPIN];
  pmx_pins_t sts_q;
  pmx_pins_t mask_q;
  logic [31:0] hcfg_q;
  logic ap_wr_q;
  logic [7:0] ap_addr_q;
  logic rd_clr;
  logic [31:0] rdata_d;
  pmx_pins_t pin_o_d;
  pmx_pins_t pin_oe_d;
  pmx_pins_t pin_pu_d;
  pmx_pins_t pin_in;
  logic tp_own;
  logic vcc_ok;
  logic ps2_clk_d;
  logic ps2_dat_d;
  logic ap_take;
  logic [7:0] a_ofs;

  // ==========================================================
  // Input synchronisers and event detection
  pmx_sync u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .raw ({vcc_pwrgd, tp_rst_n, pin_i}),
    .bus (bus.sync)
  );

  pmx_intdet u_det (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .bus (bus.det)
  );

  assign tp_own = bus.lvl[`PMX_S_TPRST]; // R01
  assign vcc_ok = bus.lvl[`PMX_S_VCCOK];

  // Test pins ignore their control while the port owns them
  always_comb begin
    for (int i = 0; i < `PMX_NPIN; i++) begin
      bus.idet[i] = (tp_own && i <= `PMX_P_TMS) ? PMX_ID_OFF :
                    pmx_f_idet(ctrl_q[i]); // R01 R05 R08 R10
    end
  end

  // Data inputs seen by software; battery and wake-only cut off
  assign pin_in = bus.lvl[`PMX_NPIN-1:0] & ~`PMX_WAKE_PINS; // R04 R08

  // ==========================================================
  // AHB-Lite slave
  assign ap_take = hready && hsel && htrans[1];
  assign a_ofs = haddr[7:0];
  assign rd_clr = ap_take && !hwrite && a_ofs == `PMX_OFS_INT_STS;

  always_comb begin
    rdata_d = 32'h0000_0000;
    for (int i = 0; i < `PMX_NPIN; i++) begin
      if (a_ofs == 8'(4 * i)) begin
        rdata_d = ctrl_q[i];
      end
    end
    case (a_ofs)
      `PMX_OFS_INT_STS: rdata_d = {19'h0, sts_q};
      `PMX_OFS_INT_MASK: rdata_d = {19'h0, mask_q};
      `PMX_OFS_PIN_IN: rdata_d = {19'h0, pin_in};
      `PMX_OFS_HOST_CFG: rdata_d = hcfg_q;
      `PMX_OFS_STATUS: rdata_d = {31'h0, tp_own};
      default: ;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= 8'h00;
    end else if (hready) begin
      ap_wr_q <= ap_take && hwrite;
      ap_addr_q <= a_ofs;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ap_take && !hwrite) begin
        hrdata <= rdata_d;
      end
    end
  end

  // ==========================================================
  // Pin control registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < `PMX_NPIN; i++) begin
        ctrl_q[i] <= `PMX_CTRL_RST;
      end
      ctrl_q[`PMX_P_STRAP] <= `PMX_CTRL_STRAP_RST; // R12
      ctrl_q[`PMX_P_IRQW] <= `PMX_CTRL_IRQW_RST;
      ctrl_q[`PMX_P_VBAT] <= `PMX_CTRL_IRQW_RST;
    end else if (ap_wr_q) begin
      for (int i = 0; i < `PMX_NPIN; i++) begin
        if (ap_addr_q == 8'(4 * i)) begin
          ctrl_q[i] <= hwdata & `PMX_CTRL_WMASK; // R14
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mask_q <= '0;
      hcfg_q <= 32'h0000_0000;
    end else if (ap_wr_q) begin
      if (ap_addr_q == `PMX_OFS_INT_MASK) begin
        mask_q <= hwdata[`PMX_NPIN-1:0];
      end
      if (ap_addr_q == `PMX_OFS_HOST_CFG) begin
        hcfg_q <= hwdata & `PMX_HC_WMASK; // R11
      end
    end
  end

  // ==========================================================
  // Interrupt status, cleared by read, set wins
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sts_q <= '0;
    end else begin
      sts_q <= (rd_clr ? '0 : sts_q) | bus.evt; // R08 R10
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq <= 1'b0;
      wake <= 1'b0;
    end else begin
      irq <= |(sts_q & mask_q);
      wake <= |(sts_q & `PMX_WAKE_PINS); // R10
    end
  end

  // ==========================================================
  // Pin drive selection
  always_comb begin
    for (int i = 0; i < `PMX_NPIN; i++) begin
      pin_pu_d[i] = ctrl_q[i][`PMX_PU_BIT];
      if (ctrl_q[i][`PMX_OD_BIT]) begin
        pin_o_d[i] = 1'b0;
        pin_oe_d[i] = ctrl_q[i][`PMX_DIR_BIT] & ~ctrl_q[i][`PMX_OUT_BIT];
      end else begin
        pin_o_d[i] = ctrl_q[i][`PMX_OUT_BIT];
        pin_oe_d[i] = ctrl_q[i][`PMX_DIR_BIT];
      end
      if (pmx_f_mux(ctrl_q[i]) != PMX_MUX_GPIO) begin
        pin_o_d[i] = 1'b0;
        pin_oe_d[i] = 1'b0;
      end
    end
    if (tp_own) begin
      pin_o_d[`PMX_P_TMS:0] = 4'(tp_tdo) << `PMX_P_TDO; // R01
      pin_oe_d[`PMX_P_TMS:0] = 4'h1 << `PMX_P_TDO; // R01
      pin_pu_d[`PMX_P_TMS:0] = 4'h0;
    end
    // Battery and wake-only pins stay inputs
    pin_o_d = pin_o_d & ~`PMX_WAKE_PINS; // R04 R08
    pin_oe_d = pin_oe_d & ~`PMX_WAKE_PINS; // R04 R08
    pin_pu_d = pin_pu_d & ~`PMX_WAKE_PINS; // R05 R08
    // PS/2 segments, open-drain from shared controller
    for (int i = `PMX_P_PS2A_CLK; i <= `PMX_P_PS2B_DAT; i++) begin
      if (pmx_f_mux(ctrl_q[i]) == PMX_MUX_ALT1) begin
        pin_oe_d[i] = i[0] ? ps2_dat_low : ps2_clk_low; // R06
      end
    end
    // Debug UART, silenced when protected and supply down
    if (pmx_f_mux(ctrl_q[`PMX_P_UART]) == PMX_MUX_ALT1) begin
      pin_o_d[`PMX_P_UART] = hcfg_q[`PMX_HC_OWN_BIT] ? uart_tx_host :
                             uart_tx_ec; // R11
      pin_oe_d[`PMX_P_UART] = ~(hcfg_q[`PMX_HC_PWR_BIT] & ~vcc_ok); // R11
    end
    // PECI request, always driven low or released
    if (pmx_f_mux(ctrl_q[`PMX_P_PECI]) == PMX_MUX_ALT1) begin
      pin_o_d[`PMX_P_PECI] = 1'b0; // R13
      pin_oe_d[`PMX_P_PECI] = peci_req_low;
    end
  end

  // PS/2 receive: wired-AND of the segments in PS/2 mode
  always_comb begin
    ps2_clk_d = 1'b1;
    ps2_dat_d = 1'b1;
    for (int i = `PMX_P_PS2A_CLK; i <= `PMX_P_PS2B_DAT; i++) begin
      if (pmx_f_mux(ctrl_q[i]) == PMX_MUX_ALT1 && i[0]) begin
        ps2_dat_d = ps2_dat_d & bus.lvl[i]; // R06
      end else if (pmx_f_mux(ctrl_q[i]) == PMX_MUX_ALT1) begin
        ps2_clk_d = ps2_clk_d & bus.lvl[i]; // R06
      end
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_o <= '0;
      pin_oe <= '0;
      pin_pu <= `PMX_PU_RST; // R12
    end else begin
      pin_o <= pin_o_d;
      pin_oe <= pin_oe_d;
      pin_pu <= pin_pu_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tp_tdi <= 1'b0;
      tp_tck <= 1'b0;
      tp_tms <= 1'b0;
      tp_owned <= 1'b0;
      ps2_clk_in <= 1'b1;
      ps2_dat_in <= 1'b1;
    end else begin
      tp_tdi <= tp_own & bus.lvl[`PMX_P_TDI]; // R02 R03
      tp_tck <= tp_own & bus.lvl[`PMX_P_TCK]; // R02 R03
      tp_tms <= tp_own & bus.lvl[`PMX_P_TMS]; // R02 R03
      tp_owned <= tp_own;
      ps2_clk_in <= ps2_clk_d;
      ps2_dat_in <= ps2_dat_d;
    end
  end

  // ==========================================================
  // Checks
  property p_tp_own;
    @(posedge clk_sys) disable iff (sys_rst)
    tp_own |=> !pin_oe[`PMX_P_TCK] && pin_oe[`PMX_P_TDO] &&
      pin_o[`PMX_P_TDO] == $past(tp_tdo);
  endproperty
  a_tp_own: assert property (p_tp_own) // R01
    else $error("test port pins not owned by test port");
  property p_tp_release;
    @(posedge clk_sys) disable iff (sys_rst)
    !tp_own && pmx_f_mux(ctrl_q[`PMX_P_TMS]) == PMX_MUX_GPIO &&
      !ctrl_q[`PMX_P_TMS][`PMX_OD_BIT]
      |=> pin_oe[`PMX_P_TMS] == $past(ctrl_q[`PMX_P_TMS][`PMX_DIR_BIT]);
  endproperty
  a_tp_release: assert property (p_tp_release) // R02
    else $error("released test pin ignores its control register");
  property p_tp_no_route;
    @(posedge clk_sys) disable iff (sys_rst)
    !tp_own |=> !tp_tck && !tp_tms && !tp_tdi;
  endproperty
  a_tp_no_route: assert property (p_tp_no_route) // R03
    else $error("test port reached while not owning pins");
  property p_vbat_fixed;
    @(posedge clk_sys) disable iff (sys_rst)
    !pin_oe[`PMX_P_VBAT] && !pin_pu[`PMX_P_VBAT] &&
      !pin_in[`PMX_P_VBAT];
  endproperty
  a_vbat_fixed: assert property (p_vbat_fixed) // R04 R05
    else $error("battery pin driven or data path connected");
  property p_ps2_share;
    @(posedge clk_sys) disable iff (sys_rst)
    ps2_clk_low &&
      pmx_f_mux(ctrl_q[`PMX_P_PS2A_CLK]) == PMX_MUX_ALT1 &&
      pmx_f_mux(ctrl_q[`PMX_P_PS2B_CLK]) == PMX_MUX_ALT1
      |=> pin_oe[`PMX_P_PS2A_CLK] && pin_oe[`PMX_P_PS2B_CLK];
  endproperty
  a_ps2_share: assert property (p_ps2_share) // R06
    else $error("shared PS/2 clock not on both segments");
  property p_irqw_only;
    @(posedge clk_sys) disable iff (sys_rst)
    !pin_oe[`PMX_P_IRQW] && !pin_in[`PMX_P_IRQW];
  endproperty
  a_irqw_only: assert property (p_irqw_only) // R08
    else $error("wake-only pin has a data path");
  property p_wake;
    @(posedge clk_sys) disable iff (sys_rst)
    bus.evt[`PMX_P_IRQW] |=> sts_q[`PMX_P_IRQW] ##1 wake;
  endproperty
  a_wake: assert property (p_wake) // R10
    else $error("wake pin event did not raise wake");
  property p_uart_protect;
    @(posedge clk_sys) disable iff (sys_rst)
    hcfg_q[`PMX_HC_PWR_BIT] && !vcc_ok &&
      pmx_f_mux(ctrl_q[`PMX_P_UART]) == PMX_MUX_ALT1
      |=> !pin_oe[`PMX_P_UART];
  endproperty
  a_uart_protect: assert property (p_uart_protect) // R11
    else $error("protected UART pin driven without supply");
  property p_strap_pu;
    @(posedge clk_sys) disable iff (sys_rst)
    $fell(sys_rst) |-> pin_pu[`PMX_P_STRAP] ##1 pin_pu[`PMX_P_STRAP];
  endproperty
  a_strap_pu: assert property (p_strap_pu) // R12
    else $error("strap pin pull-up off after reset");

endmodule : pmx_top

`default_nettype wire

// file: dv/test_pin_function_mux_exceptions.sv
`include "pmx_params.svh"
`default_nettype none

module test_pin_function_mux_exceptions;
  timeunit 1ns;
  timeprecision 1ns;
  import pmx_pkg::*;

  // ==========================================================
  // Signals
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  pmx_pins_t pin_i = '0;
  pmx_pins_t pin_o;
  pmx_pins_t pin_oe;
  pmx_pins_t pin_pu;
  logic tp_rst_n = 1'b1;
  logic vcc_pwrgd = 1'b1;
  logic tp_tdo = 1'b1;
  logic ps2_clk_low = 1'b0;
  logic ps2_dat_low = 1'b0;
  logic uart_tx_host = 1'b1;
  logic uart_tx_ec = 1'b0;
  logic peci_req_low = 1'b0;
  logic tp_tdi;
  logic tp_tck;
  logic tp_tms;
  logic tp_owned;
  logic ps2_clk_in;
  logic ps2_dat_in;
  logic irq;
  logic wake;
  int num_errors = 0;
  int checks = 0;

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  always #50 clk_sys = ~clk_sys;

  pmx_top u_pmx_top (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_pu(pin_pu), .tp_rst_n(tp_rst_n), .vcc_pwrgd(vcc_pwrgd),
    .tp_tdo(tp_tdo), .tp_tdi(tp_tdi), .tp_tck(tp_tck), .tp_tms(tp_tms),
    .tp_owned(tp_owned), .ps2_clk_low(ps2_clk_low),
    .ps2_dat_low(ps2_dat_low), .ps2_clk_in(ps2_clk_in),
    .ps2_dat_in(ps2_dat_in), .uart_tx_host(uart_tx_host),
    .uart_tx_ec(uart_tx_ec), .peci_req_low(peci_req_low), .irq(irq),
    .wake(wake)
  );

  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_sys);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsel <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 50);
    rd = hrdata;
    chk("hresp", hresp, 32'h0);
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                      input string nm);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(nm, r, exp);
  endtask : rchk

  // Sync chain plus output register, with margin
  task automatic settle();
    repeat (6) @(posedge clk_sys);
    #10;
  endtask : settle

  task automatic results();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    @(posedge clk_sys);
    #10;
    chk("pin_pu rst", pin_pu, 32'h0800);
    chk("pin_oe rst", pin_oe, 32'h0);
    rchk(8'h2c, 32'h1, "strap ctrl");
    rchk(8'h10, 32'h1000, "vbat ctrl");
    rchk(8'h14, 32'h1000, "wake ctrl");
    rchk(`PMX_OFS_INT_MASK, 32'h0, "mask rst");
    wr(8'ha0, 32'hffff_ffff);
    rchk(8'ha0, 32'h0, "unmapped");
  endtask : t_reset

  task automatic t_tport();
    pin_i[3:0] <= 4'b1101;
    settle();
    chk("owned", tp_owned, 32'h1);
    chk("tp copy", {tp_tdi, tp_tck, tp_tms}, 32'h7);
    chk("tdo drive", {pin_oe[1], pin_o[1]}, {tp_tdo, tp_tdo});
    rchk(`PMX_OFS_STATUS, 32'h1, "status");
    wr(8'h04, 32'h0000_000c);
    tp_tdo <= 1'b0;
    settle();
    chk("tdo kept", pin_o[1], 32'h0);
    @(posedge clk_sys) tp_rst_n <= 1'b0;
    settle();
    chk("released", {tp_owned, tp_tdi, tp_tck, tp_tms}, 32'h0);
    chk("gpio pin1", {pin_oe[1], pin_o[1]}, 32'h3);
    for (int i = 1; i < 4; i++) begin
      wr(8'h00, {18'h0, i[1:0], 12'h0});
      wr(8'h08, {18'h0, i[1:0], 12'h0});
      settle();
      chk("no route", {tp_tdi, tp_tck, tp_tms}, 32'h0);
    end
    wr(8'h00, 32'hffff_ffff);
    rchk(8'h00, 32'h30ff, "wmask");
  endtask : t_tport

  task automatic t_vbat();
    logic [31:0] r;
    wr(8'h10, 32'h0000_102f);
    pin_i[4] <= 1'b1;
    settle();
    chk("vbat oe", pin_oe[4], 32'h0);
    chk("vbat pu", pin_pu[4], 32'h0);
    chk("vbat wake", wake, 32'h1);
    chk("vbat irq", irq, 32'h0);
    ahb(1'b0, `PMX_OFS_PIN_IN, 32'h0, r);
    chk("vbat in", r[4], 32'h0);
    ahb(1'b0, `PMX_OFS_INT_STS, 32'h0, r);
    chk("vbat sts", r[4], 32'h1);
    wr(8'h10, 32'h0000_1000);
    pin_i[4] <= 1'b0;
    ahb(1'b0, `PMX_OFS_INT_STS, 32'h0, r);
    rchk(`PMX_OFS_INT_STS, 32'h0, "sts clr");
    settle();
    chk("wake off", wake, 32'h0);
  endtask : t_vbat

  task automatic t_wake();
    wr(8'h14, 32'h0000_103d);
    pin_i[5] <= 1'b1;
    settle();
    chk("w5 oe", pin_oe[5], 32'h0);
    chk("w5 wake", wake, 32'h1);
    chk("w5 masked", irq, 32'h0);
    wr(`PMX_OFS_INT_MASK, 32'h20);
    settle();
    chk("w5 irq", irq, 32'h1);
    rchk(`PMX_OFS_INT_STS, 32'h20, "w5 sts");
    settle();
    chk("w5 clr", {irq, wake}, 32'h0);
    @(posedge clk_sys) pin_i[5] <= 1'b0;
    settle();
    chk("w5 fall", irq, 32'h0);
    wr(8'h14, 32'h0000_1050);
    pin_i[5] <= 1'b1;
    settle();
    chk("w5 both", irq, 32'h1);
    rchk(`PMX_OFS_INT_STS, 32'h20, "w5 bsts");
    wr(8'h14, 32'h0000_1040);
    pin_i[5] <= 1'b0;
    settle();
    rchk(`PMX_OFS_INT_STS, 32'h20, "w5 fsts");
    wr(8'h14, 32'h0000_1010);
    rchk(`PMX_OFS_INT_STS, 32'h20, "w5 low");
    wr(8'h14, 32'h0000_1000);
  endtask : t_wake

  task automatic t_ps2();
    wr(8'h18, 32'h1000);
    wr(8'h1c, 32'h1000);
    wr(8'h20, 32'h2000);
    wr(8'h24, 32'h2000);
    pin_i[9:6] <= 4'b0010;
    ps2_clk_low <= 1'b1;
    settle();
    chk("a clk", {pin_oe[6], pin_o[6]}, 32'h2);
    chk("b idle", pin_oe[8], 32'h0);
    chk("a in", {ps2_clk_in, ps2_dat_in}, 32'h1);
    wr(8'h18, 32'h2000);
    wr(8'h1c, 32'h2000);
    wr(8'h20, 32'h1000);
    wr(8'h24, 32'h1000);
    ps2_clk_low <= 1'b0;
    ps2_dat_low <= 1'b1;
    pin_i[9:6] <= 4'b0101;
    settle();
    chk("b dat", {pin_oe[9], pin_o[9], pin_oe[7]}, 32'h4);
    chk("b in", {ps2_clk_in, ps2_dat_in}, 32'h2);
    wr(8'h18, 32'h1000);
    ps2_clk_low <= 1'b1;
    settle();
    chk("a b clk", {pin_oe[6], pin_oe[8]}, 32'h3);
    @(posedge clk_sys) ps2_dat_low <= 1'b0;
    ps2_clk_low <= 1'b0;
  endtask : t_ps2

  task automatic t_uart();
    wr(8'h28, 32'h1000);
    wr(`PMX_OFS_HOST_CFG, 32'h2);
    settle();
    chk("uart host", {pin_oe[10], pin_o[10]}, 32'h3);
    rchk(`PMX_OFS_HOST_CFG, 32'h2, "host cfg");
    uart_tx_host <= 1'b0;
    uart_tx_ec <= 1'b1;
    wr(`PMX_OFS_HOST_CFG, 32'h0);
    settle();
    chk("uart ec", {pin_oe[10], pin_o[10]}, 32'h3);
    wr(`PMX_OFS_HOST_CFG, 32'h1);
    vcc_pwrgd <= 1'b0;
    settle();
    chk("uart prot", pin_oe[10], 32'h0);
    @(posedge clk_sys) vcc_pwrgd <= 1'b1;
    settle();
    chk("uart vcc", pin_oe[10], 32'h1);
  endtask : t_uart

  task automatic t_peci();
    wr(8'h30, 32'h1002);
    peci_req_low <= 1'b1;
    settle();
    chk("peci low", {pin_oe[12], pin_o[12]}, 32'h2);
    @(posedge clk_sys) peci_req_low <= 1'b0;
    settle();
    chk("peci rel", pin_oe[12], 32'h0);
  endtask : t_peci

  // ==========================================================
  // Sequence and watchdog
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_tport();
    t_vbat();
    t_wake();
    t_ps2();
    t_uart();
    t_peci();
    results();
  end

  initial begin
    #2000000;
    num_errors++;
    results();
  end

endmodule : test_pin_function_mux_exceptions

`default_nettype wire
